// ===== hw/tcc_channel.sv
// One channel of a 16-bit up-counting timer: counter, compare and capture logic.
// Assumes a plain register port in the clk domain and raw asynchronous trigger pins.
//
// Contract
// - Registers A and B each select compare (0, default) or capture (1).
// - Counter equal to A compare value pulses compare A and sets its flag.
// - Counter equal to B value pulses compare B, sets flag, clears counter.
// - Compare values are 16 bits; match comes after value plus one counts.
// - With buffering on, matches use shadow copies of the compare values.
// - Shadow copies load from both compare registers on compare B.
// - Edge field: 3 both, 2 falling, 1 rising, 0 none.
// - Selected edge while counting copies counter, sets capture flag.
// - Capture while its flag is still set sets the overwrite flag.
// - Compare function ignores the edge field and never captures.
// - Capture function produces no compare signal.
// - Repeat mode keeps counting, also through overflow wrap.
// - One-shot mode stops the counter on compare B.
// - Dual-edge enable matches A against the double-rate counter.
// - Only the normal counter is readable, never the dual-edge one.
// - Writing 1 to reset clears the counter to zero.
// - Run bit 1 counts, 0 holds the counter for resumption.
`timescale 1ns/1ps

module tcc_channel
    import tcc_pkg::*;
#(
    parameter int CW = 16,
    parameter int AW = 4
)(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [CW-1:0] reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [CW-1:0] reg_rdata,
    input  wire logic          trigger_pin_a,
    input  wire logic          trigger_pin_b,
    output logic               compare_a,
    output logic               compare_b,
    output logic               counter_clear,
    output logic               channel_irq
);

    localparam int NF = `TCC_NUM_FLAGS;

    logic                counter_run_bit;
    logic                count_repeat_oneshot_sel;
    logic                dual_edge_compare_enable;
    logic                shadow_buffer_enable;
    tcc_func_t           reg_a_function_select;
    tcc_func_t           reg_b_function_select;
    tcc_edge_sel_t       trigger_edge_sel_a;
    tcc_edge_sel_t       trigger_edge_sel_b;
    logic [CW-1:0]       count;
    logic [CW-1:0]       match_or_snapshot_reg_a;
    logic [CW-1:0]       match_or_snapshot_reg_b;
    logic [CW-1:0]       shadow_a;
    logic [CW-1:0]       shadow_b;
    logic [NF-1:0]       flags;
    logic [NF-1:0]       irq_en;

    logic                next_run;
    logic                next_oneshot;
    logic                next_dual;
    logic                next_bufen;
    tcc_func_t           next_func_a;
    tcc_func_t           next_func_b;
    tcc_edge_sel_t       next_trig_a;
    tcc_edge_sel_t       next_trig_b;
    logic [CW-1:0]       next_count;
    logic [CW-1:0]       next_reg_a;
    logic [CW-1:0]       next_reg_b;
    logic [CW-1:0]       next_shadow_a;
    logic [CW-1:0]       next_shadow_b;
    logic [NF-1:0]       next_flags;
    logic [NF-1:0]       next_irq_en;
    logic                next_compare_a;
    logic                next_compare_b;
    logic                next_counter_clear;
    logic [CW-1:0]       next_rdata;

    logic                rise_a;
    logic                fall_a;
    logic                rise_b;
    logic                fall_b;
    logic                wr_ctrl;
    logic                wr_reset;
    logic [CW-1:0]       ref_a;
    logic [CW-1:0]       ref_b;
    logic [CW-1:0]       dual_count;
    logic                match_a;
    logic                match_b;
    logic                cap_a;
    logic                cap_b;
    logic [NF-1:0]       flag_set;
    logic [NF-1:0]       flag_clr;

    // trigger synchronisers
    // Edges are only seen reliably when each phase spans more than one clock.
    tcc_edge_sync u_sync_a (
        .clk  (clk),
        .rst  (rst),
        .pin  (trigger_pin_a),
        .rise (rise_a),
        .fall (fall_a)
    );

    tcc_edge_sync u_sync_b (
        .clk  (clk),
        .rst  (rst),
        .pin  (trigger_pin_b),
        .rise (rise_b),
        .fall (fall_b)
    );

    assign wr_ctrl  = reg_wr && (reg_addr == `TCC_ADDR_CTRL);
    assign wr_reset = wr_ctrl && reg_wdata[`TCC_CTRL_RESET];

    // shadow selection
    // Buffered compare keeps a period coherent while software rewrites values.
    assign ref_a = shadow_buffer_enable ? shadow_a : match_or_snapshot_reg_a;
    assign ref_b = shadow_buffer_enable ? shadow_b : match_or_snapshot_reg_b;

    // dual-edge counter
    // Advances two per clock; the odd value lies in the second half of the clock,
    // so an odd A value matches in the clock whose falling half holds it.
    assign dual_count = {count[CW-2:0], 1'b0};

    always_comb begin
        if (dual_edge_compare_enable) begin
            match_a = (dual_count[CW-1:1] == ref_a[CW-1:1]);
        end else begin
            match_a = (count == ref_a);
        end
        match_a = match_a && counter_run_bit && (reg_a_function_select == tcc_func_compare);
    end

    assign match_b = counter_run_bit && (reg_b_function_select == tcc_func_compare)
                     && (count == ref_b);

    assign cap_a = counter_run_bit && (reg_a_function_select == tcc_func_capture)
                   && ((trigger_edge_sel_a[`TCC_EDGE_RISE] && rise_a)
                       || (trigger_edge_sel_a[`TCC_EDGE_FALL] && fall_a));
    assign cap_b = counter_run_bit && (reg_b_function_select == tcc_func_capture)
                   && ((trigger_edge_sel_b[`TCC_EDGE_RISE] && rise_b)
                       || (trigger_edge_sel_b[`TCC_EDGE_FALL] && fall_b));

    // Control and counter next values.
    always_comb begin
        next_run     = counter_run_bit;
        next_oneshot = count_repeat_oneshot_sel;
        next_dual    = dual_edge_compare_enable;
        next_bufen   = shadow_buffer_enable;
        next_func_a  = reg_a_function_select;
        next_func_b  = reg_b_function_select;
        next_trig_a  = trigger_edge_sel_a;
        next_trig_b  = trigger_edge_sel_b;
        next_irq_en  = irq_en;
        next_count   = count;
        if (wr_ctrl) begin
            next_run     = reg_wdata[`TCC_CTRL_RUN];
            next_oneshot = reg_wdata[`TCC_CTRL_ONESHOT];
            next_dual    = reg_wdata[`TCC_CTRL_DUAL];
            next_bufen   = reg_wdata[`TCC_CTRL_BUFEN];
        end else if (match_b && count_repeat_oneshot_sel) begin
            next_run = 1'b0;
        end
        if (reg_wr && (reg_addr == `TCC_ADDR_CCCTL)) begin
            next_func_a = tcc_func_t'(reg_wdata[`TCC_CC_FUNC_A]);
            next_func_b = tcc_func_t'(reg_wdata[`TCC_CC_FUNC_B]);
            next_trig_a = reg_wdata[`TCC_CC_TRIG_A_HI:`TCC_CC_TRIG_A_LO];
            next_trig_b = reg_wdata[`TCC_CC_TRIG_B_HI:`TCC_CC_TRIG_B_LO];
        end
        if (reg_wr && (reg_addr == `TCC_ADDR_IRQ_EN)) begin
            next_irq_en = reg_wdata[NF-1:0];
        end
        // counter update; a wrap from all ones keeps counting.
        if (wr_reset || match_b) begin
            next_count = '0;
        end else if (counter_run_bit) begin
            next_count = count + 1'b1;
        end
    end

    // Compare/capture register and shadow next values.
    always_comb begin
        next_reg_a    = match_or_snapshot_reg_a;
        next_reg_b    = match_or_snapshot_reg_b;
        next_shadow_a = shadow_a;
        next_shadow_b = shadow_b;
        // software write
        // Each write lands in one clock, so spacing by a count clock is always met.
        if (reg_wr && (reg_addr == `TCC_ADDR_REG_A)) begin
            next_reg_a = reg_wdata;
        end
        if (reg_wr && (reg_addr == `TCC_ADDR_REG_B)) begin
            next_reg_b = reg_wdata;
        end
        // counter capture
        // A capture beats a software write landing in the same clock.
        if (cap_a) begin
            next_reg_a = count;
        end
        if (cap_b) begin
            next_reg_b = count;
        end
        // shadow load
        // Unbuffered, the shadows track so enabling starts from current values.
        if (match_b || !shadow_buffer_enable) begin
            next_shadow_a = match_or_snapshot_reg_a;
            next_shadow_b = match_or_snapshot_reg_b;
        end
    end

    // sticky flags; a set in the clearing clock wins.
    always_comb begin
        flag_set = '0;
        flag_set[`TCC_FLAG_CMP_A] = match_a;
        flag_set[`TCC_FLAG_CMP_B] = match_b;
        flag_set[`TCC_FLAG_CAP_A] = cap_a;
        flag_set[`TCC_FLAG_CAP_B] = cap_b;
        flag_set[`TCC_FLAG_OVW_A] = cap_a && flags[`TCC_FLAG_CAP_A];
        flag_set[`TCC_FLAG_OVW_B] = cap_b && flags[`TCC_FLAG_CAP_B];
        flag_clr = '0;
        if (reg_wr && (reg_addr == `TCC_ADDR_FLAGS)) begin
            flag_clr = reg_wdata[NF-1:0];
        end
        next_flags = (flags & ~flag_clr) | flag_set;
    end

    // Event outputs and read data.
    // the dual-edge counter has no entry in the read map.
    always_comb begin
        next_compare_a     = match_a;
        next_compare_b     = match_b;
        next_counter_clear = wr_reset || match_b;
        next_rdata         = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                `TCC_ADDR_CTRL: begin
                    next_rdata[`TCC_CTRL_RUN]     = counter_run_bit;
                    next_rdata[`TCC_CTRL_ONESHOT] = count_repeat_oneshot_sel;
                    next_rdata[`TCC_CTRL_DUAL]    = dual_edge_compare_enable;
                    next_rdata[`TCC_CTRL_BUFEN]   = shadow_buffer_enable;
                end
                `TCC_ADDR_COUNT:  next_rdata = count;
                `TCC_ADDR_REG_A:  next_rdata = match_or_snapshot_reg_a;
                `TCC_ADDR_REG_B:  next_rdata = match_or_snapshot_reg_b;
                `TCC_ADDR_CCCTL: begin
                    next_rdata[`TCC_CC_FUNC_A] = reg_a_function_select;
                    next_rdata[`TCC_CC_FUNC_B] = reg_b_function_select;
                    next_rdata[`TCC_CC_TRIG_A_HI:`TCC_CC_TRIG_A_LO] = trigger_edge_sel_a;
                    next_rdata[`TCC_CC_TRIG_B_HI:`TCC_CC_TRIG_B_LO] = trigger_edge_sel_b;
                end
                `TCC_ADDR_FLAGS:  next_rdata[NF-1:0] = flags;
                `TCC_ADDR_IRQ_EN: next_rdata[NF-1:0] = irq_en;
                default:          next_rdata = '0;
            endcase
        end
    end

    // State registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            counter_run_bit          <= 1'b0;
            count_repeat_oneshot_sel <= 1'b0;
            dual_edge_compare_enable <= 1'b0;
            shadow_buffer_enable     <= 1'b0;
            reg_a_function_select    <= tcc_func_compare;
            reg_b_function_select    <= tcc_func_compare;
            trigger_edge_sel_a       <= `TCC_EDGE_NONE;
            trigger_edge_sel_b       <= `TCC_EDGE_NONE;
            count                    <= `TCC_RST_WORD;
            match_or_snapshot_reg_a  <= `TCC_RST_WORD;
            match_or_snapshot_reg_b  <= `TCC_RST_WORD;
            shadow_a                 <= `TCC_RST_WORD;
            shadow_b                 <= `TCC_RST_WORD;
            flags                    <= `TCC_RST_FLAGS;
            irq_en                   <= `TCC_RST_FLAGS;
            compare_a                <= 1'b0;
            compare_b                <= 1'b0;
            counter_clear            <= 1'b0;
            reg_rdata                <= `TCC_RST_WORD;
        end else begin
            counter_run_bit          <= next_run;
            count_repeat_oneshot_sel <= next_oneshot;
            dual_edge_compare_enable <= next_dual;
            shadow_buffer_enable     <= next_bufen;
            reg_a_function_select    <= next_func_a;
            reg_b_function_select    <= next_func_b;
            trigger_edge_sel_a       <= next_trig_a;
            trigger_edge_sel_b       <= next_trig_b;
            count                    <= next_count;
            match_or_snapshot_reg_a  <= next_reg_a;
            match_or_snapshot_reg_b  <= next_reg_b;
            shadow_a                 <= next_shadow_a;
            shadow_b                 <= next_shadow_b;
            flags                    <= next_flags;
            irq_en                   <= next_irq_en;
            compare_a                <= next_compare_a;
            compare_b                <= next_compare_b;
            counter_clear            <= next_counter_clear;
            reg_rdata                <= next_rdata;
        end
    end

    assign channel_irq = |(flags & irq_en);

    // Checks on the channel behaviour.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_b_match;
        match_b && !wr_ctrl;
    endsequence

    sequence s_counter_cleared;
        (count == '0) && compare_b && flags[`TCC_FLAG_CMP_B];
    endsequence

    a_cmp_a_event: assert property (
        (match_a && !dual_edge_compare_enable) |-> (count == ref_a)
        ##1 (compare_a && flags[`TCC_FLAG_CMP_A])
    ) else $error("compare A event missing or misplaced");

    a_cmp_b_clear: assert property (
        s_b_match |=> s_counter_cleared
    ) else $error("compare B did not clear the counter");

    a_shadow_load: assert property (
        (match_b && shadow_buffer_enable)
        |=> (shadow_a == $past(match_or_snapshot_reg_a))
            && (shadow_b == $past(match_or_snapshot_reg_b))
    ) else $error("shadow buffers not loaded on compare B");

    a_capture_copy: assert property (
        cap_a |=> (match_or_snapshot_reg_a == $past(count)) && flags[`TCC_FLAG_CAP_A]
    ) else $error("capture A did not store the counter");

    a_overwrite_flag: assert property (
        (cap_b && flags[`TCC_FLAG_CAP_B]) |=> flags[`TCC_FLAG_OVW_B]
    ) else $error("overwrite B flag not set");

    a_compare_no_capture: assert property (
        ((reg_a_function_select == tcc_func_compare) && !reg_wr)
        |=> $stable(match_or_snapshot_reg_a)
    ) else $error("register A changed while in compare function");

    a_capture_no_cmp: assert property (
        (reg_b_function_select == tcc_func_capture) [*2] |-> !compare_b
    ) else $error("compare B pulsed in capture function");

    a_repeat_wrap: assert property (
        (counter_run_bit && !count_repeat_oneshot_sel && (count == '1) && !match_b && !reg_wr)
        |=> counter_run_bit && (count == '0) ##1 (count == CW'(1) || match_b)
    ) else $error("repeat mode did not keep counting through wrap");

    a_oneshot_stop: assert property (
        (s_b_match and count_repeat_oneshot_sel) |=> !counter_run_bit ##1 (count == '0)
    ) else $error("one-shot counter kept running");

    a_reset_clear: assert property (
        wr_reset |=> (count == '0) && counter_clear
    ) else $error("counter reset write ignored");

    a_stop_hold: assert property (
        (!counter_run_bit && !wr_reset) |=> $stable(count)
    ) else $error("stopped counter moved");

    a_flag_sticky: assert property (
        (flags[`TCC_FLAG_CMP_A] && !(reg_wr && (reg_addr == `TCC_ADDR_FLAGS)))
        |=> flags[`TCC_FLAG_CMP_A]
    ) else $error("compare A flag dropped without a clear");

    a_irq_gate: assert property (
        (flags[`TCC_FLAG_CAP_A] && irq_en[`TCC_FLAG_CAP_A]) |-> channel_irq
    ) else $error("enabled flag did not raise the interrupt");

endmodule

// ===== shared/tcc_defines.svh
// Register offsets, field positions and reset values of the timer compare/capture channel.
// Assumes inclusion by bare name from the package and from the bench.
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// Word offsets on the register port.
`define TCC_ADDR_CTRL     4'h0
`define TCC_ADDR_COUNT    4'h1
`define TCC_ADDR_REG_A    4'h2
`define TCC_ADDR_REG_B    4'h3
`define TCC_ADDR_CCCTL    4'h4
`define TCC_ADDR_FLAGS    4'h5
`define TCC_ADDR_IRQ_EN   4'h6

// Channel control fields.
`define TCC_CTRL_RUN      0
`define TCC_CTRL_RESET    1
`define TCC_CTRL_ONESHOT  2
`define TCC_CTRL_DUAL     3
`define TCC_CTRL_BUFEN    4

// Compare/capture control fields.
`define TCC_CC_FUNC_A     0
`define TCC_CC_FUNC_B     1
`define TCC_CC_TRIG_A_LO  2
`define TCC_CC_TRIG_A_HI  3
`define TCC_CC_TRIG_B_LO  4
`define TCC_CC_TRIG_B_HI  5

// Trigger edge select bits: bit 0 rising, bit 1 falling, both set means both edges.
`define TCC_EDGE_RISE     0
`define TCC_EDGE_FALL     1
`define TCC_EDGE_NONE     2'h0

// Flag and enable positions.
`define TCC_FLAG_CMP_A    0
`define TCC_FLAG_CMP_B    1
`define TCC_FLAG_CAP_A    2
`define TCC_FLAG_CAP_B    3
`define TCC_FLAG_OVW_A    4
`define TCC_FLAG_OVW_B    5
`define TCC_NUM_FLAGS     6

// Reset values.
`define TCC_RST_WORD      16'h0000
`define TCC_RST_FLAGS     6'h00

`endif

// ===== shared/tcc_pkg.sv
// Types shared by the timer compare/capture channel.
// Assumes the defines header sits beside it on the include path.
`include "tcc_defines.svh"

package tcc_pkg;

    // Function of one channel register: compare is the reset default.
    typedef enum logic {
        tcc_func_compare,
        tcc_func_capture
    } tcc_func_t;

    // Trigger edge selection field.
    typedef logic [1:0] tcc_edge_sel_t;

endpackage

// ===== hw/tcc_edge_sync.sv
// Two-stage synchroniser and edge detector for one capture trigger pin.
// Assumes the pin is asynchronous to clk and each level lasts over one clock.
`timescale 1ns/1ps

module tcc_edge_sync
    import tcc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      rise,
    output logic      fall
);

    logic meta;
    logic sync;
    logic prev;
    logic next_meta;
    logic next_sync;
    logic next_prev;

    // Only the second stage and its delayed copy feed the edge logic.
    always_comb begin
        next_meta = pin;
        next_sync = meta;
        next_prev = sync;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
        end
    end

    // One-cycle pulses on each settled transition.
    assign rise = sync & ~prev;
    assign fall = ~sync & prev;

endmodule

// ===== tb/tcc_trig_model.sv
// Model of the two external sources that drive the capture trigger pins.
// Assumes the bench requests levels in the clk domain and holds each for several clocks.
`timescale 1ns/1ps

module tcc_trig_model #(
    parameter int LAG = 3
)(
    input  wire logic clk,
    input  wire logic req_a,
    input  wire logic req_b,
    output logic      pin_a,
    output logic      pin_b
);
    logic [LAG-1:0] dly_a = '0;
    logic [LAG-1:0] dly_b = '0;

    // phases stay wide
    // A plain delay line never shortens a phase, so a slow source is modelled with LAG.
    always @(posedge clk) begin
        dly_a <= {dly_a[LAG-2:0], req_a};
        dly_b <= {dly_b[LAG-2:0], req_b};
    end

    // The pins change just after the rising clock edge, the same edge that samples them.
    assign pin_a = dly_a[LAG-1];
    assign pin_b = dly_b[LAG-1];
endmodule

// ===== tb/timer_compare_capture_modes_tb_top.sv
// Self-checking bench for one compare/capture timer channel.
// Assumes the channel counts once per clk and answers reads one cycle later.
`timescale 1ns/1ps
`include "tcc_defines.svh"

module timer_compare_capture_modes_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic [15:0] rdata;
    logic        req_a = 1'b0;
    logic        req_b = 1'b0;
    logic        pin_a;
    logic        pin_b;
    logic        cmp_a;
    logic        cmp_b;
    logic        clr;
    logic        irq;
    int          errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          t0;
    int          qr[$];
    int          qa[$];
    int          qb[$];
    bit          rd_pend = 1'b0;
    logic [31:0] seed = 32'h0000_0054;

    tcc_channel dut (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .trigger_pin_a(pin_a),
        .trigger_pin_b(pin_b), .compare_a(cmp_a), .compare_b(cmp_b),
        .counter_clear(clr), .channel_irq(irq));
    tcc_trig_model #(.LAG(3)) src (.clk(clk), .req_a(req_a), .req_b(req_b),
        .pin_a(pin_a), .pin_b(pin_b));

    // Free-running clock and a cycle index used to time expected events.
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task end_sim;
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A write leaves t0 at the index of the edge that took it.
    // writes one clock apart
    // The strobe drops for a clock between calls, so compare writes never follow back to back.
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(negedge clk);
        t0 = cyc;
    endtask

    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        qr.push_back(e);
        @(posedge clk);
        rd_s <= 1'b0;
    endtask

    task pulse_pins;
        @(posedge clk);
        req_a <= 1'b1;
        req_b <= 1'b1;
        repeat (6) @(posedge clk);
        req_a <= 1'b0;
        req_b <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    // Expected events sit at fixed offsets from the run edge; one-shot gives one period.
    task cmp_run(input logic [15:0] a, input logic [15:0] b, input logic [15:0] mode, int np);
        int ea;
        ea = mode[3] ? a / 2 : a;
        wr(`TCC_ADDR_REG_A, a);
        wr(`TCC_ADDR_REG_B, b);
        wr(`TCC_ADDR_CTRL, mode | 16'h0003);
        for (int p = 0; p < np; p++) begin
            qa.push_back(t0 + ea + 1 + p * (b + 1));
            qb.push_back(t0 + b + 1 + p * (b + 1));
        end
        // The stop lands in the clock of the third B match and before a fourth A match can start.
        repeat (3 * (b + 1) - 2) @(posedge clk);
        wr(`TCC_ADDR_CTRL, 16'h0000);
    endtask

    // Results are matched in arrival order against the notes left by the driver.
    always @(negedge clk) begin
        if (rd_pend) begin
            cmp_count++;
            if (qr.size() == 0 || rdata !== 16'(qr.pop_front())) begin
                errors++;
                $display("unexpected %0t read data %h", $time, rdata);
            end
        end
        rd_pend = rd_s;
        if (cmp_a === 1'b1) begin
            cmp_count++;
            if (qa.size() == 0 || qa.pop_front() != cyc) begin
                errors++;
                $display("unexpected %0t compare a at %0d", $time, cyc);
            end
        end
        if (cmp_b === 1'b1) begin
            cmp_count++;
            if (qb.size() == 0 || qb.pop_front() != cyc || clr !== 1'b1) begin
                errors++;
                $display("unexpected %0t compare b at %0d", $time, cyc);
            end
        end
    end

    initial begin
        #(25 * 80000);
        errors++;
        $display("unexpected %0t watchdog expired", $time);
        end_sim();
    end

    initial begin
        int b;
        int n2;
        logic [15:0] e;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(`TCC_ADDR_CTRL, 16'h0000);
        rd(`TCC_ADDR_CCCTL, 16'h0000);
        rd(`TCC_ADDR_REG_A, 16'h0000);
        // compare-only repeat, dual-edge and one-shot modes
        // Both registers stay in compare, no A interrupt is enabled and B stays small.
        for (int m = 0; m < 3; m++) begin
            b = 4 + rnd() % 8;
            cmp_run(16'(rnd() % (m == 1 ? 2 * b : b)), 16'(b), m == 1 ? 16'h8 : m == 2 ? 16'h4 : 16'h0,
                m == 2 ? 1 : 3);
        end
        rd(`TCC_ADDR_COUNT, 16'h0000);
        rd(`TCC_ADDR_FLAGS, 16'h0003);
        n2 = 7 + rnd() % 4;
        wr(`TCC_ADDR_REG_A, 16'hFFFF);
        wr(`TCC_ADDR_REG_B, 16'h0004);
        wr(`TCC_ADDR_CTRL, 16'h0013);
        qb.push_back(t0 + 5);
        qb.push_back(t0 + 5 + n2 + 1);
        wr(`TCC_ADDR_REG_B, 16'(n2));
        // Leave before a third B match so the capture phase starts clean.
        repeat (n2 + 4) @(posedge clk);
        wr(`TCC_ADDR_CTRL, 16'h0001);
        wr(`TCC_ADDR_IRQ_EN, 16'h0004);
        for (int c = 0; c < 4; c++) begin
            wr(`TCC_ADDR_CCCTL, 16'(c * 20 + 3));
            wr(`TCC_ADDR_FLAGS, 16'h003F);
            pulse_pins();
            e = (c != 0 ? 16'h000C : 16'h0000) | (c == 3 ? 16'h0030 : 16'h0000);
            rd(`TCC_ADDR_FLAGS, e);
            cmp_count++;
            if (irq !== (c != 0)) begin
                errors++;
                $display("unexpected %0t interrupt line %b", $time, irq);
            end
        end
        wr(`TCC_ADDR_REG_A, 16'hFFFF);
        wr(`TCC_ADDR_REG_B, 16'hFFFF);
        wr(`TCC_ADDR_CCCTL, 16'h003C);
        wr(`TCC_ADDR_FLAGS, 16'h003F);
        pulse_pins();
        rd(`TCC_ADDR_FLAGS, 16'h0000);
        // wrap through overflow
        // Capture with no edge keeps B from matching, so the counter must wrap and go on.
        wr(`TCC_ADDR_CCCTL, 16'h0003);
        wr(`TCC_ADDR_CTRL, 16'h0003);
        repeat (65540) @(posedge clk);
        rd(`TCC_ADDR_COUNT, 16'h0005);
        wr(`TCC_ADDR_CTRL, 16'h0000);
        wr(`TCC_ADDR_CTRL, 16'h0002);
        rd(`TCC_ADDR_COUNT, 16'h0000);
        rd(`TCC_ADDR_CTRL, 16'h0000);
        rd(4'h7, 16'h0000);
        repeat (4) @(posedge clk);
        if (qa.size() != 0 || qb.size() != 0 || qr.size() != 0) begin
            errors++;
            $display("unexpected %0t missing events", $time);
        end
        end_sim();
    end
endmodule
